// ---- low_side_channel_consts.vh ----
// constants of the eight-channel low-side switch control logic
`ifndef LOW_SIDE_CHANNEL_CONSTS_VH
`define LOW_SIDE_CHANNEL_CONSTS_VH

// clock and timing
`define MCLK_PERIOD_PS       5000
`define RESTART_TIME_US      1000
// restart time over the clock period, sized to the restart counter
`define RESTART_CYC_DEFAULT  18'd200000
`define RESTART_CNT_W        18

// serial frame
`define FRAME_BITS           16
`define FRAME_CNT_W          8
`define BYTE_BITS            3
`define OPC_MSB              15
`define OPC_LSB              14
`define OPC_READ             2'h0
`define OPC_ON_CMD           2'h1
`define OPC_MAP              2'h2
`define OPC_CLEAR            2'h3
`define MAP_SEL_BIT          8
`define OL_EN_BIT            8
`define RD_SEL_MSB           1
`define RD_SEL_LSB           0

// read-back selectors
`define RD_FAULT             2'h0
`define RD_OSM               2'h1
`define RD_ON_CMD            2'h2
`define RD_TEMP              2'h3

// reset values
`define ON_CMD_RST           8'h00
`define MAP_A_RST            8'h04
`define MAP_B_RST            8'h08
`define OL_EN_RST            1'b0
`define RD_SEL_RST           2'h0

// fixed fail-safe channels
`define FS_CH_A              2
`define FS_CH_B              3

`endif

// ---- channel_guard.v ----
// per-channel fault latch with fail-safe automatic restart
`timescale 1ns/1ps
`default_nettype none

`include "low_side_channel_consts.vh"

module channel_guard #(
  parameter [`RESTART_CNT_W-1:0] RESTART_CYC = `RESTART_CYC_DEFAULT
) (
  input  wire mclk,
  input  wire rst_n,
  input  wire drive,
  input  wire gate_on,
  input  wire overload,
  input  wire overtemp,
  input  wire clear,
  input  wire fail_safe,
  output wire fault,
  output wire temp_fault
);

  reg                      ovl_q;
  reg                      ot_q;
  reg  [`RESTART_CNT_W-1:0] retry_q;
  wire                     retry_done;
  wire                     ovl_hit;
  wire                     ot_hit;

  assign ovl_hit    = overload & gate_on;
  assign ot_hit     = overtemp;
  assign retry_done = fail_safe & drive & (retry_q == RESTART_CYC);
  assign fault      = ovl_q | ot_q;
  assign temp_fault = ot_q;

  // a new trip wins over a clear in the same cycle
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovl_q <= 1'b0;
      ot_q  <= 1'b0;
    end
    else
    begin
      if (ovl_hit)
        ovl_q <= 1'b1;
      else if (clear | retry_done)
        ovl_q <= 1'b0;
      if (ot_hit)
        ot_q <= 1'b1;
      else if (clear | retry_done)
        ot_q <= 1'b0;
    end
  end

  // restart delay runs only while the driving pin stays high
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      retry_q <= {`RESTART_CNT_W{1'b0}};
    else if (fault & fail_safe & drive & ~retry_done)
      retry_q <= retry_q + 1'b1;
    else
      retry_q <= {`RESTART_CNT_W{1'b0}};
  end

endmodule // channel_guard

`default_nettype wire

// ---- low_side_channel_control.v ----
// serial control, input mapping, fail-safe and protection of eight channels
`timescale 1ns/1ps
`default_nettype none

// How it works
// - frames are sixteen bits long
// - bits pass through for daisy chains
// - reset maps each pin to one channel
// - serial command remaps each pin
// - several channels may follow one pin
// - fail-safe drives channels 2 and 3 directly
// - fail-safe pins work without digital supply
// - serial port works only with supply
// - overload latches channel off until cleared
// - fail-safe fault restarts after delay
// - per-channel over-temperature latches off
// - latched diagnosis readable over serial
// - off-state monitor reports open load
// - test source only on serial command
// - traffic accepted only while select low
// - data output released while select high
// - idle pin high enters low-power idle

`include "low_side_channel_consts.vh"

module low_side_channel_control #(
  parameter                     CHANNELS    = 8,
  parameter [`RESTART_CNT_W-1:0] RESTART_CYC = `RESTART_CYC_DEFAULT
) (
  input  wire                mclk,
  input  wire                rst_n,
  input  wire                sclk,
  input  wire                select_low,
  input  wire                si,
  input  wire                direct_ctrl_pin_a,
  input  wire                direct_ctrl_pin_b,
  input  wire                idle_req,
  input  wire                vdd_present,
  input  wire [CHANNELS-1:0] overload_trip_current,
  input  wire [CHANNELS-1:0] over_temp,
  input  wire [CHANNELS-1:0] open_load_sense,
  output reg                 so_out,
  output reg                 so_oe_n,
  output reg  [CHANNELS-1:0] gate_on,
  output reg  [CHANNELS-1:0] open_load_test_source,
  output reg                 fail_safe_mode,
  output reg                 idle_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam SYNC_W = 6 + 3 * CHANNELS;

  reg  [SYNC_W-1:0]   meta_q;
  reg  [SYNC_W-1:0]   sync_q;
  wire [SYNC_W-1:0]   pins_raw;
  wire                sclk_s;
  wire                sel_low_s;
  wire                si_s;
  wire                pin_a_s;
  wire                pin_b_s;
  wire                vdd_s;
  wire [CHANNELS-1:0] ovl_s;
  wire [CHANNELS-1:0] ot_s;
  wire [CHANNELS-1:0] ols_s;

  assign pins_raw = {open_load_sense, over_temp, overload_trip_current,
                     vdd_present, direct_ctrl_pin_b, direct_ctrl_pin_a,
                     si, select_low, sclk};

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // select rests high so no false select edge follows reset
      meta_q <= {{(SYNC_W-2){1'b0}}, 2'b10};
      sync_q <= {{(SYNC_W-2){1'b0}}, 2'b10};
    end
    else
    begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
    end
  end

  assign sclk_s    = sync_q[0];
  assign sel_low_s = sync_q[1];
  assign si_s      = sync_q[2];
  assign pin_a_s   = sync_q[3];
  assign pin_b_s   = sync_q[4];
  assign vdd_s     = sync_q[5];
  assign ovl_s     = sync_q[6 +: CHANNELS];
  assign ot_s      = sync_q[6 + CHANNELS +: CHANNELS];
  assign ols_s     = sync_q[6 + 2 * CHANNELS +: CHANNELS];

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on the serial pins

  reg  sclk_d_q;
  reg  sel_d_q;
  reg  si_bit_q;
  wire sclk_rise;
  wire sclk_fall;
  wire sel_fall;
  wire sel_rise;
  wire port_on;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_d_q <= 1'b0;
      sel_d_q  <= 1'b1;
    end
    else
    begin
      sclk_d_q <= sclk_s;
      sel_d_q  <= sel_low_s;
    end
  end

  assign port_on   = vdd_s & ~idle_mode;
  assign sclk_rise = sclk_s & ~sclk_d_q & ~sel_low_s & port_on;
  assign sclk_fall = ~sclk_s & sclk_d_q & ~sel_low_s & port_on;
  assign sel_fall  = ~sel_low_s & sel_d_q & port_on;
  assign sel_rise  = sel_low_s & ~sel_d_q & port_on;

  ////////////////////////////////////////////////////////////////////////////
  // frame shifter: sample on rising, shift on falling

  reg  [`FRAME_BITS-1:0]  shift_q;
  reg  [`FRAME_CNT_W-1:0] bit_cnt_q;
  reg  [1:0]              rd_sel_q;
  reg  [CHANNELS-1:0]     on_cmd_q;
  reg  [CHANNELS-1:0]     map_a_q;
  reg  [CHANNELS-1:0]     map_b_q;
  reg  [CHANNELS-1:0]     osm_q;
  reg                     ol_en_q;
  reg  [`FRAME_BITS-1:0]  reply;
  wire [CHANNELS-1:0]     fault;
  wire [CHANNELS-1:0]     temp_fault;
  wire                    frame_ok;
  wire [1:0]              opc;
  wire [CHANNELS-1:0]     clear_mask;

  always @*
  begin
    reply = {`FRAME_BITS{1'b0}};
    reply[15] = fail_safe_mode;
    reply[14] = idle_mode;
    reply[13] = pin_b_s;
    reply[12] = pin_a_s;
    reply[9:8] = rd_sel_q;
    case (rd_sel_q)
      `RD_FAULT:  reply[7:0] = fault;
      `RD_OSM:    reply[7:0] = osm_q;
      `RD_ON_CMD: reply[7:0] = on_cmd_q;
      `RD_TEMP:   reply[7:0] = temp_fault;
      default:    reply[7:0] = 8'h00;
    endcase
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q   <= {`FRAME_BITS{1'b0}};
      bit_cnt_q <= {`FRAME_CNT_W{1'b0}};
      si_bit_q  <= 1'b0;
    end
    else if (sel_fall)
    begin
      shift_q   <= reply;
      bit_cnt_q <= {`FRAME_CNT_W{1'b0}};
    end
    else if (sclk_rise)
    begin
      si_bit_q <= si_s;
      if (bit_cnt_q != {`FRAME_CNT_W{1'b1}})
        bit_cnt_q <= bit_cnt_q + 1'b1;
    end
    else if (sclk_fall)
      shift_q <= {shift_q[`FRAME_BITS-2:0], si_bit_q};
  end

  // last sixteen bits kept when the chain is whole bytes long
  assign frame_ok = sel_rise
                  & (bit_cnt_q >= `FRAME_BITS)
                  & (bit_cnt_q[`BYTE_BITS-1:0] == 3'h0);
  assign opc        = shift_q[`OPC_MSB:`OPC_LSB];
  assign clear_mask = (frame_ok && opc == `OPC_CLEAR) ?
                      shift_q[CHANNELS-1:0] : {CHANNELS{1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // command registers

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_cmd_q <= `ON_CMD_RST;
      map_a_q  <= `MAP_A_RST;
      map_b_q  <= `MAP_B_RST;
      ol_en_q  <= `OL_EN_RST;
      rd_sel_q <= `RD_SEL_RST;
    end
    else if (frame_ok)
    begin
      case (opc)
        `OPC_READ:
          rd_sel_q <= shift_q[`RD_SEL_MSB:`RD_SEL_LSB];
        `OPC_ON_CMD:
          on_cmd_q <= shift_q[CHANNELS-1:0];
        `OPC_MAP:
        begin
          if (shift_q[`MAP_SEL_BIT])
            map_b_q <= shift_q[CHANNELS-1:0];
          else
            map_a_q <= shift_q[CHANNELS-1:0];
        end
        `OPC_CLEAR:
          ol_en_q <= shift_q[`OL_EN_BIT];
        default:
          rd_sel_q <= rd_sel_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel drive

  reg  [CHANNELS-1:0] drive;
  wire                fs_now;
  reg                 idle_req_s;
  reg                 idle_meta_q;

  // fail-safe when the digital supply is gone and idle is low
  assign fs_now = ~vdd_s & ~idle_req_s;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idle_meta_q <= 1'b0;
      idle_req_s  <= 1'b0;
    end
    else
    begin
      idle_meta_q <= idle_req;
      idle_req_s  <= idle_meta_q;
    end
  end

  always @*
  begin
    drive = {CHANNELS{1'b0}};
    if (fs_now)
    begin
      drive[`FS_CH_A] = pin_a_s;
      drive[`FS_CH_B] = pin_b_s;
    end
    else
      drive = on_cmd_q
            | (map_a_q & {CHANNELS{pin_a_s}})
            | (map_b_q & {CHANNELS{pin_b_s}});
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : g_chan
      channel_guard #(
        .RESTART_CYC (RESTART_CYC)
      ) u_guard (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .drive      (drive[ch]),
        .gate_on    (gate_on[ch]),
        .overload   (ovl_s[ch]),
        .overtemp   (ot_s[ch]),
        .clear      (clear_mask[ch]),
        .fail_safe  (fail_safe_mode),
        .fault      (fault[ch]),
        .temp_fault (temp_fault[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_on               <= {CHANNELS{1'b0}};
      open_load_test_source <= {CHANNELS{1'b0}};
      osm_q                 <= {CHANNELS{1'b0}};
      fail_safe_mode        <= 1'b0;
      idle_mode             <= 1'b0;
      so_out                <= 1'b0;
      so_oe_n               <= 1'b1;
    end
    else
    begin
      fail_safe_mode <= fs_now;
      idle_mode      <= idle_req_s & ~fs_now;
      if (idle_req_s & ~fs_now)
        gate_on <= {CHANNELS{1'b0}};
      else
        gate_on <= drive & ~fault;
      // monitor bits only track channels that are off
      osm_q <= ols_s & ~gate_on;
      open_load_test_source <= {CHANNELS{ol_en_q & vdd_s}}
                             & ~gate_on;
      so_out  <= shift_q[`FRAME_BITS-1];
      so_oe_n <= sel_low_s | ~port_on;
    end
  end

endmodule // low_side_channel_control

`default_nettype wire

// ---- lsc_checker.sv ----
// port assertions of the eight-channel switch control logic
`timescale 1ns/1ps
`default_nettype none
module lsc_checker #(
  parameter CHANNELS = 8
) (
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire logic                select_low,
  input wire logic                vdd_present,
  input wire logic                idle_req,
  input wire logic [CHANNELS-1:0] over_temp,
  input wire logic                so_oe_n,
  input wire logic [CHANNELS-1:0] gate_on,
  input wire logic [CHANNELS-1:0] open_load_test_source,
  input wire logic                fail_safe_mode,
  input wire logic                idle_mode
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sel_release_a: assert property
    (select_low [*6] |-> so_oe_n) else $error("so driven unselected");
  supply_off_a: assert property
    (!vdd_present [*6] |-> so_oe_n) else $error("so driven no supply");
  idle_enter_a: assert property
    ((idle_req && vdd_present) [*8] |-> idle_mode) else $error("no idle");
  idle_off_a: assert property
    (idle_mode [*3] |-> gate_on == 0) else $error("channel on in idle");
  fs_enter_a: assert property
    ((!vdd_present && !idle_req) [*6] |-> fail_safe_mode)
    else $error("no fail-safe");
  fs_chan_a: assert property
    (fail_safe_mode [*4] |-> gate_on[7:4] == 4'h0 && gate_on[1:0] == 2'h0)
    else $error("wrong channel in fail-safe");
  src_supply_a: assert property
    (!vdd_present [*5] |-> open_load_test_source == 0)
    else $error("test source without supply");
  hot_off_a: assert property
    (!fail_safe_mode |-> (gate_on & over_temp & $past(over_temp, 1)
      & $past(over_temp, 2) & $past(over_temp, 3) & $past(over_temp, 4)
      & $past(over_temp, 5)) == 0) else $error("hot channel on");
endmodule // lsc_checker
bind low_side_channel_control lsc_checker #(.CHANNELS(CHANNELS)) chk (
  .mclk(mclk), .rst_n(rst_n), .select_low(select_low),
  .vdd_present(vdd_present), .idle_req(idle_req), .over_temp(over_temp),
  .so_oe_n(so_oe_n), .gate_on(gate_on),
  .open_load_test_source(open_load_test_source),
  .fail_safe_mode(fail_safe_mode), .idle_mode(idle_mode));
`default_nettype wire

// ---- spi_master_model.sv ----
// serial master model driving the switch's serial port
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  input  wire logic mclk,
  input  wire logic so_w,
  output var  logic sclk,
  output var  logic select_low,
  output var  logic si
);
  initial
  begin
    sclk = 1'b0;
    select_low = 1'b1;
    si = 1'b0;
  end
  task automatic half(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // nb bits of tx, msb first; reply shifted into rx
  task automatic xfer(input logic [31:0] tx, input int nb,
                      output logic [31:0] rx);
    rx = 32'h0;
    @(posedge mclk);
    select_low <= 1'b0;
    for (int i = nb - 1; i >= 0; i--)
    begin
      si <= tx[i];
      half(13);
      sclk <= 1'b1;
      rx = {rx[30:0], so_w};
      half(12);
      sclk <= 1'b0;
    end
    half(13);
    select_low <= 1'b1;
    si <= 1'b0;
    half(10);
  endtask
endmodule // spi_master_model
`default_nettype wire

// ---- tb_low_side_channel_control.sv ----
// self-checking bench of the switch control logic
`timescale 1ns/1ps
`default_nettype none
`include "low_side_channel_consts.vh"
module tb_low_side_channel_control;
  logic        mclk, rst_n, pa, pb, idle, vdd, sclk, sel_n, si;
  logic        so, so_oe_n, fsm, idm, so_w;
  logic [7:0]  ovl, ot, ols, gate, src, ma, mb, on;
  logic [31:0] rx, s;
  int          n_errors, cmp_count;
  low_side_channel_control #(.RESTART_CYC(18'd20)) dut (
    .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .select_low(sel_n), .si(si),
    .direct_ctrl_pin_a(pa), .direct_ctrl_pin_b(pb), .idle_req(idle),
    .vdd_present(vdd), .overload_trip_current(ovl), .over_temp(ot),
    .open_load_sense(ols), .so_out(so), .so_oe_n(so_oe_n),
    .gate_on(gate), .open_load_test_source(src),
    .fail_safe_mode(fsm), .idle_mode(idm));
  spi_master_model m (.mclk(mclk), .so_w(so_w), .sclk(sclk),
    .select_low(sel_n), .si(si));
  assign so_w = so_oe_n ? 1'bz : so;
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [7:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s[7:0];
  endfunction
  function automatic logic [7:0] want(input logic a, input logic b);
    return on | (a ? ma : 8'h00) | (b ? mb : 8'h00);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [1:0] op, input logic b8,
                       input logic [7:0] d);
    m.xfer({16'h0000, op, 5'h00, b8, d}, 16, rx);
  endtask
  task automatic settle();
    repeat (8) @(posedge mclk);
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    summarize();
  end
  initial
  begin
    s = 32'h95B5;
    n_errors = 0;
    cmp_count = 0;
    {rst_n, pa, pb, idle, vdd, ovl, ot, ols} = {5'b00001, 24'h000000};
    {ma, mb, on} = {8'h04, 8'h08, 8'h00};
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    settle();
    pa <= 1'b1;
    settle();
    chk(gate, want(1'b1, 1'b0));
    pb <= 1'b1;
    settle();
    chk(gate, want(1'b1, 1'b1));
    for (int k = 0; k < 3; k++)
    begin
      pa <= 1'b1;
      ma = rnd();
      mb = rnd();
      frame(`OPC_MAP, 1'b0, ma);
      frame(`OPC_MAP, 1'b1, mb);
      chk(gate, want(1'b1, 1'b1));
      pa <= 1'b0;
      settle();
      chk(gate, want(1'b0, 1'b1));
    end
    pa <= 1'b0;
    pb <= 1'b0;
    on = rnd();
    frame(`OPC_ON_CMD, 1'b0, on);
    chk(gate, want(1'b0, 1'b0));
    m.xfer({20'h0, `OPC_ON_CMD, 10'h000}, 12, rx);
    chk(gate, want(1'b0, 1'b0));
    on = ~on;
    m.xfer({8'h00, 8'hA5, `OPC_ON_CMD, 6'h00, on}, 24, rx);
    chk(gate, want(1'b0, 1'b0));
    chk(rx[7:0], 8'hA5);
    frame(`OPC_READ, 1'b0, `RD_ON_CMD);
    frame(`OPC_READ, 1'b0, `RD_FAULT);
    chk(rx[9:0], {`RD_ON_CMD, on});
    on = 8'hFF;
    frame(`OPC_ON_CMD, 1'b0, on);
    ovl <= 8'h20;
    settle();
    ovl <= 8'h00;
    settle();
    chk(gate, 8'hDF);
    frame(`OPC_READ, 1'b0, `RD_TEMP);
    chk(rx[7:0], 8'h20);
    frame(`OPC_CLEAR, 1'b0, 8'h20);
    chk(gate, 8'hFF);
    ot <= 8'h02;
    settle();
    ot <= 8'h00;
    frame(`OPC_READ, 1'b0, `RD_OSM);
    chk(gate, 8'hFD);
    chk(rx[7:0], 8'h02);
    frame(`OPC_CLEAR, 1'b0, 8'h02);
    chk(gate, 8'hFF);
    on = 8'h00;
    frame(`OPC_ON_CMD, 1'b0, on);
    chk(src, 8'h00);
    ols <= rnd();
    frame(`OPC_CLEAR, 1'b1, 8'h00);
    chk(src, 8'hFF);
    frame(`OPC_CLEAR, 1'b0, 8'h00);
    chk(rx[7:0], ols);
    chk(src, 8'h00);
    vdd <= 1'b0;
    pa <= 1'b1;
    settle();
    chk(fsm, 1'b1);
    chk(gate, 8'h04);
    frame(`OPC_ON_CMD, 1'b0, 8'hFF);
    chk(gate, 8'h04);
    ovl <= 8'h04;
    repeat (6) @(posedge mclk);
    chk(gate, 8'h00);
    ovl <= 8'h00;
    repeat (40) @(posedge mclk);
    chk(gate, 8'h04);
    vdd <= 1'b1;
    idle <= 1'b1;
    settle();
    chk(idm, 1'b1);
    chk(gate, 8'h00);
    settle();
    summarize();
  end
endmodule // tb_low_side_channel_control
`default_nettype wire
